// ### src/iom_io_space.sv
`timescale 1ns/1ps
`include "iom_consts.svh"

module iom_io_space (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Core request
   input  wire iom_pkg::iom_req_t req,
   // Core answer
   output      iom_pkg::iom_rsp_t rsp,
   // Pin levels and peripheral events
   input  wire iom_pkg::iom_port_t pinLevels,
   input  wire iom_pkg::iom_evt_t  timerEvents,
   // Register contents to the ports
   output      iom_pkg::iom_port_t portDir,
   output      iom_pkg::iom_port_t portOut,
   output      logic [7:0]         portCtrl
);
   import iom_pkg::*;

   iom_state_t state_reg;
   iom_state_t state_next;

   // Implemented bits of a register; zero for reserved locations
   function automatic logic [7:0] implMask(input logic [5:0] a);
      case (a)
         `IOM_ADR_PORT_A_INPUT_LEVELS, `IOM_ADR_PORT_A_DIRECTION, `IOM_ADR_PORT_A_OUTPUT_VALUE: implMask = `IOM_MASK_A;
         `IOM_ADR_TFLG0:                              implMask = `IOM_MASK_TFLG0;
         `IOM_ADR_TFLG1:                              implMask = `IOM_MASK_TFLG1;
         `IOM_ADR_PORT_B_INPUT_LEVELS, `IOM_ADR_PORT_B_DIRECTION, `IOM_ADR_PORT_B_OUTPUT_VALUE,
         `IOM_ADR_PORT_C_INPUT_LEVELS, `IOM_ADR_PORT_C_DIRECTION, `IOM_ADR_PORT_C_OUTPUT_VALUE,
         `IOM_ADR_PORT_D_INPUT_LEVELS, `IOM_ADR_PORT_D_DIRECTION, `IOM_ADR_PORT_D_OUTPUT_VALUE,
         `IOM_ADR_PCTRL:                              implMask = 8'hFF;
         default:                                     implMask = 8'h00;
      endcase
   endfunction

   // Read value of one I/O location
   function automatic logic [7:0] readReg(input iom_state_t s, input iom_port_t pins,
                                          input logic [5:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `IOM_ADR_PORT_A_INPUT_LEVELS:  v = pins.a;
         `IOM_ADR_PORT_A_DIRECTION:  v = s.dir.a;
         `IOM_ADR_PORT_A_OUTPUT_VALUE: v = s.outv.a;
         `IOM_ADR_PORT_B_INPUT_LEVELS:  v = pins.b;
         `IOM_ADR_PORT_B_DIRECTION:  v = s.dir.b;
         `IOM_ADR_PORT_B_OUTPUT_VALUE: v = s.outv.b;
         `IOM_ADR_PORT_C_INPUT_LEVELS:  v = pins.c;
         `IOM_ADR_PORT_C_DIRECTION:  v = s.dir.c;
         `IOM_ADR_PORT_C_OUTPUT_VALUE: v = s.outv.c;
         `IOM_ADR_PORT_D_INPUT_LEVELS:  v = pins.d;
         `IOM_ADR_PORT_D_DIRECTION:  v = s.dir.d;
         `IOM_ADR_PORT_D_OUTPUT_VALUE: v = s.outv.d;
         `IOM_ADR_PCTRL: v = s.pctrl;
         `IOM_ADR_TFLG0: v = s.tflg0;
         `IOM_ADR_TFLG1: v = s.tflg1;
         default:        v = 8'h00;
      endcase
      readReg = v & implMask(a);
   endfunction

   // Decode results and write masks of the current request
   logic [5:0] ioAddr;
   logic       inIoSpace;
   logic       bitRange;
   logic       isWrite;
   logic       isBitOp;
   logic [7:0] bitOne;
   logic [7:0] rdVal;
   logic [7:0] plainW;
   logic [7:0] setW;
   logic [7:0] clrW;
   logic [7:0] m;

   // Address decode of both access paths
   // Both paths share one decode so a register never has two copies
   always_comb begin
      inIoSpace = 1'b0;
      ioAddr    = 6'h00;
      if (req.dataSpace) begin
         // Loads and stores reach I/O at offset 0x20; above is extended space
         // Below the offset lies other storage, so those addresses are refused too
         if (req.addr >= `IOM_DS_OFFSET && req.addr <= `IOM_DS_IO_TOP) begin
            inIoSpace = 1'b1;
            ioAddr    = 6'(req.addr - `IOM_DS_OFFSET);
         end
      end else begin
         // The I/O opcode field is six bits; addresses with either upper bit set are refused here
         inIoSpace = (req.addr[7:6] == 2'b00);
         ioAddr    = req.addr[5:0];
      end
   end

   // Value of a control register after a write or bit operation
   function automatic logic [7:0] wrVal(input logic [7:0] old, input logic [7:0] pw,
                                        input logic [7:0] sw, input logic [7:0] cw,
                                        input iom_op_t op);
      case (op)
         IOM_OP_WRITE: wrVal = pw;
         IOM_OP_SETB:  wrVal = old | sw;
         IOM_OP_CLRB:  wrVal = old & ~cw;
         default:      wrVal = old;
      endcase
   endfunction

   // Flag update: written ones clear, events set; an event in the same cycle wins
   // Only implemented bits are kept, so reserved flag bits always read zero
   function automatic logic [7:0] flagNext(input logic [7:0] old, input logic clr,
                                           input logic [7:0] ones, input logic [7:0] ev,
                                           input logic [7:0] mask);
      flagNext = ((clr ? (old & ~ones) : old) | ev) & mask;
   endfunction

   // Next state of the whole bank
   always_comb begin
      state_next = state_reg;
      isBitOp    = (req.op == IOM_OP_SETB) || (req.op == IOM_OP_CLRB) ||
                   (req.op == IOM_OP_TESTB);
      bitRange   = inIoSpace && !req.dataSpace && (ioAddr <= `IOM_BIT_TOP);
      isWrite    = 1'b0;
      bitOne     = 8'h01 << req.bitSel;
      rdVal      = readReg(state_reg, pinLevels, ioAddr);
      plainW     = 8'h00;
      setW       = 8'h00;
      clrW       = 8'h00;
      m          = implMask(ioAddr);

      // Refused requests get only an error pulse, never data or a skip
      state_next.rsp            = '0;
      state_next.rsp.ioRangeErr = (req.op != IOM_OP_NONE) &&
                                  (!inIoSpace || (isBitOp && !bitRange));
      case (req.op)
         IOM_OP_NONE: begin
         end
         IOM_OP_READ: begin
            state_next.rsp.rvalid = inIoSpace;
            state_next.rsp.rdata  = inIoSpace ? rdVal : 8'h00;
         end
         IOM_OP_WRITE: begin
            isWrite = inIoSpace;
            plainW  = req.wdata & m;
         end
         IOM_OP_SETB: begin
            // Only the selected bit moves; no read-modify-write of neighbours
            isWrite = bitRange;
            setW    = bitOne & m;
         end
         IOM_OP_CLRB: begin
            isWrite = bitRange;
            clrW    = bitOne & m;
         end
         IOM_OP_TESTB: begin
            state_next.rsp.testValid = bitRange;
            state_next.rsp.skip      = bitRange && rdVal[req.bitSel];
         end
         default: begin
         end
      endcase

      // Flags: written ones clear, events set; set wins over clear
      state_next.tflg0 = flagNext(state_reg.tflg0, isWrite && ioAddr == `IOM_ADR_TFLG0,
                                  plainW | setW, timerEvents.t0, `IOM_MASK_TFLG0);
      state_next.tflg1 = flagNext(state_reg.tflg1, isWrite && ioAddr == `IOM_ADR_TFLG1,
                                  plainW | setW, timerEvents.t1, `IOM_MASK_TFLG1);

      // Plain control registers
      if (isWrite) begin
         case (ioAddr)
            `IOM_ADR_PORT_A_DIRECTION:
               state_next.dir.a  = wrVal(state_reg.dir.a, plainW, setW, clrW, req.op);
            `IOM_ADR_PORT_A_OUTPUT_VALUE:
               state_next.outv.a = wrVal(state_reg.outv.a, plainW, setW, clrW, req.op);
            `IOM_ADR_PORT_B_DIRECTION:
               state_next.dir.b  = wrVal(state_reg.dir.b, plainW, setW, clrW, req.op);
            `IOM_ADR_PORT_B_OUTPUT_VALUE:
               state_next.outv.b = wrVal(state_reg.outv.b, plainW, setW, clrW, req.op);
            `IOM_ADR_PORT_C_DIRECTION:
               state_next.dir.c  = wrVal(state_reg.dir.c, plainW, setW, clrW, req.op);
            `IOM_ADR_PORT_C_OUTPUT_VALUE:
               state_next.outv.c = wrVal(state_reg.outv.c, plainW, setW, clrW, req.op);
            `IOM_ADR_PORT_D_DIRECTION:
               state_next.dir.d  = wrVal(state_reg.dir.d, plainW, setW, clrW, req.op);
            `IOM_ADR_PORT_D_OUTPUT_VALUE:
               state_next.outv.d = wrVal(state_reg.outv.d, plainW, setW, clrW, req.op);
            `IOM_ADR_PCTRL:
               state_next.pctrl  = wrVal(state_reg.pctrl, plainW, setW, clrW, req.op);
            default: begin
               // Input levels and reserved locations ignore writes
            end
         endcase
      end
   end

   // Single state register
   always_ff @(posedge clk) begin
      if (sys_rst)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   // Outputs come straight from the state register
   assign rsp      = state_reg.rsp;
   assign portDir  = state_reg.dir;
   assign portOut  = state_reg.outv;
   assign portCtrl = state_reg.pctrl;
endmodule

// ### src/iom_consts.svh
`ifndef IOM_CONSTS_SVH
`define IOM_CONSTS_SVH
// I/O addresses of the low register space
`define IOM_ADR_PORT_B_INPUT_LEVELS    6'h03
`define IOM_ADR_PORT_B_DIRECTION    6'h04
`define IOM_ADR_PORT_B_OUTPUT_VALUE   6'h05
`define IOM_ADR_PORT_C_INPUT_LEVELS    6'h06
`define IOM_ADR_PORT_C_DIRECTION    6'h07
`define IOM_ADR_PORT_C_OUTPUT_VALUE   6'h08
`define IOM_ADR_PORT_D_INPUT_LEVELS    6'h09
`define IOM_ADR_PORT_D_DIRECTION    6'h0A
`define IOM_ADR_PORT_D_OUTPUT_VALUE   6'h0B
`define IOM_ADR_PORT_A_INPUT_LEVELS    6'h0C
`define IOM_ADR_PORT_A_DIRECTION    6'h0D
`define IOM_ADR_PORT_A_OUTPUT_VALUE   6'h0E
`define IOM_ADR_PCTRL   6'h12
`define IOM_ADR_TFLG0   6'h15
`define IOM_ADR_TFLG1   6'h16
// Address map limits
`define IOM_BIT_TOP     6'h1F
`define IOM_DS_OFFSET   8'h20
`define IOM_DS_IO_TOP   8'h5F
// Implemented bit masks
`define IOM_MASK_A      8'h0F
`define IOM_MASK_TFLG0  8'h07
`define IOM_MASK_TFLG1  8'h27
// Reset value of every control register
`define IOM_RST_VAL     8'h00
`endif

// ### src/iom_pkg.sv
package iom_pkg;
   // Kind of access the core issues
   typedef enum logic [5:0] {
      IOM_OP_NONE  = 6'b000001,
      IOM_OP_READ  = 6'b000010,
      IOM_OP_WRITE = 6'b000100,
      IOM_OP_SETB  = 6'b001000,
      IOM_OP_CLRB  = 6'b010000,
      IOM_OP_TESTB = 6'b100000
   } iom_op_t;

   // One request from the core
   typedef struct packed {
      iom_op_t    op;
      logic       dataSpace;
      logic [7:0] addr;
      logic [2:0] bitSel;
      logic [7:0] wdata;
   } iom_req_t;

   // Answer back to the core
   typedef struct packed {
      logic       rvalid;
      logic [7:0] rdata;
      logic       testValid;
      logic       skip;
      logic       ioRangeErr;
   } iom_rsp_t;

   // All port pins, one byte per port
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
   } iom_port_t;

   // Timer event pulses
   typedef struct packed {
      logic [7:0] t0;
      logic [7:0] t1;
   } iom_evt_t;

   // Whole state of the register bank
   typedef struct packed {
      iom_port_t  dir;
      iom_port_t  outv;
      logic [7:0] pctrl;
      logic [7:0] tflg0;
      logic [7:0] tflg1;
      iom_rsp_t   rsp;
   } iom_state_t;
endpackage

// ### sim/iom_io_space_assertions.sv
`timescale 1ns/1ps
module iom_io_space_assertions (
   // Clock and reset
   input wire logic               clk,
   input wire logic               sys_rst,
   // Core side
   input wire iom_pkg::iom_req_t  req,
   input wire iom_pkg::iom_rsp_t  rsp,
   // Register outputs
   input wire iom_pkg::iom_port_t portDir,
   input wire iom_pkg::iom_port_t portOut
);
   import iom_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Decoded request kinds
   wire logic       io    = !req.dataSpace;
   wire logic       rdOp  = req.op == IOM_OP_READ;
   wire logic       live  = req.op != IOM_OP_NONE;
   wire logic [7:0] selM  = 8'h01 << req.bitSel;
   wire logic       bitOp = req.op inside {IOM_OP_SETB, IOM_OP_CLRB, IOM_OP_TESTB};
   // Refused answer: error only, nothing answered
   sequence errAns;
      rsp.ioRangeErr && !rsp.rvalid && !rsp.testValid;
   endsequence
   a_io_read: assert property (rdOp && io && req.addr <= 8'h3F |=> rsp.rvalid)
      else $error("io read lost");
   a_ds_read: assert property (rdOp && !io && req.addr inside {[8'h20:8'h5F]} |=> rsp.rvalid)
      else $error("data read lost");
   a_ext_refused: assert property (live && !io && req.addr >= 8'h60 |=> errAns)
      else $error("extended decoded");
   a_io_limit: assert property (live && io && req.addr > 8'h3F |=> errAns)
      else $error("io past 64");
   a_bit_range: assert property (bitOp && (!io || req.addr > 8'h1F) |=> errAns)
      else $error("bit op range");
   a_test_skip: assert property (req.op == IOM_OP_TESTB && io && req.addr == 8'h05
      |=> rsp.testValid && rsp.skip == |($past(portOut.b) & $past(selM)))
      else $error("skip wrong");
   a_set_only: assert property (req.op == IOM_OP_SETB && io && req.addr == 8'h05
      |=> portOut.b == ($past(portOut.b) | $past(selM)))
      else $error("set touched more");
   a_clr_only: assert property (req.op == IOM_OP_CLRB && io && req.addr == 8'h04
      |=> portDir.b == ($past(portDir.b) & ~$past(selM)))
      else $error("clear touched more");
   a_write_seen: assert property (req.op == IOM_OP_WRITE && io && req.addr == 8'h05
      |=> portOut.b == $past(req.wdata))
      else $error("write lost");
   a_rsvd_zero: assert property (rdOp && io && req.addr inside {[8'h17:8'h1A]}
      |=> rsp.rdata == 8'h00)
      else $error("reserved nonzero");
endmodule
bind iom_io_space iom_io_space_assertions iom_io_space_assertions_i (.clk(clk),
   .sys_rst(sys_rst), .req(req), .rsp(rsp), .portDir(portDir), .portOut(portOut));

// ### sim/iom_core_model.sv
`timescale 1ns/1ps
module iom_core_model (
   // From the bench
   input  wire iom_pkg::iom_req_t cmd,
   input  wire logic              rude,
   // To the register bank
   output      iom_pkg::iom_req_t req
);
   import iom_pkg::*;
   logic [7:0] ia;
   // Polite core filters its stores; rude one passes all to test refusals
   always_comb begin
      ia = cmd.addr - (cmd.dataSpace ? 8'h20 : 8'h00);
      req = cmd;
      if (!rude && cmd.op inside {IOM_OP_WRITE, IOM_OP_SETB, IOM_OP_CLRB}) begin
         if (!(ia inside {[8'h03:8'h0E], 8'h12, 8'h15, 8'h16}))
            req.op = IOM_OP_NONE;
         if (ia inside {[8'h0C:8'h0E]}) begin
            req.wdata  = cmd.wdata & 8'h0F;
            req.bitSel = {1'b0, cmd.bitSel[1:0]};
         end
      end
   end
endmodule

// ### sim/iom_io_space_test.sv
`timescale 1ns/1ps
module iom_io_space_test;
   import iom_pkg::*;
   logic        clk = 0, sys_rst = 1, rude = 0;
   logic [31:0] seed = 32'h837D;
   logic [7:0]  portCtrl, mdl [64] = '{default: 8'h00};
   iom_req_t    cmd = '{op: IOM_OP_NONE, default: '0}, req;
   iom_rsp_t    rsp;
   iom_port_t   pinLevels = '0, portDir, portOut;
   iom_evt_t    timerEvents = '0;
   int          n_mismatch = 0, compares = 0;
   // Clock
   always #12.5 clk = ~clk;
   iom_core_model iom_core_model_i (.cmd(cmd), .rude(rude), .req(req));
   iom_io_space iom_io_space_i (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
      .pinLevels(pinLevels), .timerEvents(timerEvents), .portDir(portDir),
      .portOut(portOut), .portCtrl(portCtrl));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // Implemented bits per I/O address
   function automatic logic [7:0] msk(input logic [7:0] a);
      if (a inside {[8'h03:8'h0B], 8'h12}) return 8'hFF;
      if (a inside {[8'h0C:8'h0E]}) return 8'h0F;
      if (a == 8'h15) return 8'h07;
      return a == 8'h16 ? 8'h27 : 8'h00;
   endfunction
   function automatic logic [7:0] rd(input logic [7:0] a);
      case (a)
         8'h03: return pinLevels.b;
         8'h06: return pinLevels.c;
         8'h09: return pinLevels.d;
         8'h0C: return pinLevels.a & 8'h0F;
         default: return mdl[a[5:0]] & msk(a);
      endcase
   endfunction
   // Store into the model; input levels ignore stores
   task automatic upd(input logic [7:0] a, input logic [7:0] w);
      if (a inside {8'h15, 8'h16}) mdl[a[5:0]] &= ~w;
      else if (!(a inside {8'h03, 8'h06, 8'h09, 8'h0C})) mdl[a[5:0]] = w & msk(a);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One request; expectation from what the core really sent
   task automatic xfer(input iom_op_t op, input logic ds, input logic [7:0] a,
      input logic [2:0] b, input logic [7:0] wd, input logic [15:0] ev);
      logic [7:0] ia, v, bm;
      logic ok, bok, fl;
      iom_rsp_t e;
      cmd = '{op, ds, a, b, wd};
      timerEvents = ev;
      @(negedge clk);
      ia = req.dataSpace ? req.addr - 8'h20 : req.addr;
      ok = req.dataSpace ? req.addr inside {[8'h20:8'h5F]} : req.addr <= 8'h3F;
      bok = !req.dataSpace && req.addr <= 8'h1F;
      bm = 8'h01 << req.bitSel;
      fl = ia inside {8'h15, 8'h16};
      v = rd(ia);
      e = '0;
      e.ioRangeErr = (req.op inside {IOM_OP_READ, IOM_OP_WRITE}) ? !ok : !bok;
      if (req.op == IOM_OP_NONE) e.ioRangeErr = 0;
      if (req.op == IOM_OP_READ) e.rvalid = ok;
      if (req.op == IOM_OP_READ && ok) e.rdata = v;
      if (req.op == IOM_OP_WRITE && ok) upd(ia, req.wdata);
      if (req.op == IOM_OP_SETB && bok) upd(ia, fl ? bm : mdl[ia[5:0]] | bm);
      if (req.op == IOM_OP_CLRB && bok && !fl) upd(ia, mdl[ia[5:0]] & ~bm);
      e.testValid = req.op == IOM_OP_TESTB && bok;
      e.skip = e.testValid && (v & bm) != 0;
      mdl[21] |= ev[15:8] & 8'h07;
      mdl[22] |= ev[7:0] & 8'h27;
      chk({21'h0, rsp}, {21'h0, e});
      chk(portOut, {mdl[14], mdl[5], mdl[8], mdl[11]});
      chk(portDir, {mdl[13], mdl[4], mdl[7], mdl[10]});
      chk(portCtrl, mdl[18]);
   endtask
   task automatic results();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog, run needs about 16 us
   initial begin
      #60us;
      n_mismatch++;
      results();
   end
   initial begin
      seed = xs(seed);
      pinLevels = seed;
      repeat (6) @(negedge clk);
      sys_rst = 0;
      chk(portOut | portDir | portCtrl | rsp, 32'h0);
      xfer(IOM_OP_WRITE, 0, 8'h05, 0, 8'hA5, 0);
      xfer(IOM_OP_READ, 1, 8'h25, 0, 0, 0);
      xfer(IOM_OP_TESTB, 0, 8'h05, 2, 0, 0);
      xfer(IOM_OP_SETB, 0, 8'h05, 1, 0, 16'h0700);
      xfer(IOM_OP_WRITE, 0, 8'h04, 0, 8'hFF, 0);
      xfer(IOM_OP_CLRB, 0, 8'h04, 5, 0, 0);
      xfer(IOM_OP_SETB, 0, 8'h15, 0, 0, 16'h0400);
      xfer(IOM_OP_WRITE, 0, 8'h15, 0, 8'h02, 16'h0200);
      xfer(IOM_OP_READ, 0, 8'h15, 0, 0, 0);
      xfer(IOM_OP_READ, 0, 8'h17, 0, 0, 0);
      // Random mix over the whole byte address range
      repeat (600) begin
         seed = xs(seed);
         rude = seed[23];
         xfer(iom_op_t'(6'h01 << (seed[2:0] % 3'd6)), seed[3],
            seed[11] ? seed[11:4] : {1'b0, seed[10:4]}, seed[14:12],
            seed[22:15], seed[31:28] == 0 ? seed[27:12] : 16'h0);
      end
      // Reset again mid-run; the model forgets everything as the bank does
      cmd.op = IOM_OP_NONE;
      timerEvents = '0;
      sys_rst = 1;
      @(negedge clk);
      sys_rst = 0;
      mdl = '{default: 8'h00};
      chk(portOut | portDir | portCtrl | rsp, 32'h0);
      xfer(IOM_OP_READ, 1, 8'h25, 0, 0, 0);
      results();
   end
endmodule
